// file: fsp_defines.svh
// Timing counts, pin positions and codes for the sector protection host
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

`define FSP_CLK_MHZ          200
`define FSP_PROT_PULSE_US    100
`define FSP_PROT_PULSE_CYC   (`FSP_PROT_PULSE_US * `FSP_CLK_MHZ)
`define FSP_UNPROT_PULSE_MS  10
`define FSP_UNPROT_PULSE_CYC (`FSP_UNPROT_PULSE_MS * 1000 * `FSP_CLK_MHZ)
`define FSP_SETUP_NS         100
`define FSP_SETUP_CYC        ((`FSP_SETUP_NS * `FSP_CLK_MHZ + 999) / 1000)
`define FSP_READ_NS          150
`define FSP_READ_CYC         ((`FSP_READ_NS * `FSP_CLK_MHZ + 999) / 1000)
`define FSP_CNT_W            24
`define FSP_ADDR_W           19
`define FSP_BIT_A0           0
`define FSP_BIT_A1           1
`define FSP_BIT_A6           6
`define FSP_BIT_A12          12
`define FSP_BIT_SEL_LO       16
`define FSP_VERIFY_YES       8'h01
`define FSP_VERIFY_NO        8'h00

`endif

// file: fsp_pkg.sv
// Types shared by the sector protection host
package fsp_pkg;
	typedef enum logic [1:0] {
		FSP_OP_PROTECT,
		FSP_OP_UNPROTECT,
		FSP_OP_VERIFY
	} fsp_op_t;

	typedef struct packed {
		fsp_op_t    op;
		logic [2:0] sector;
	} fsp_req_t;

	typedef struct packed {
		logic [18:0] addr;
		logic        chip_en_n;
		logic        out_en_n;
		logic        write_en_n;
		logic        mode_hv;
		logic        oe_hv;
		logic        ce_hv;
	} fsp_pins_t;
endpackage

// file: fsp_host.sv
// Host that drives sector protect, unprotect and verify on the flash pins
`timescale 1ns/1ps
`include "fsp_defines.svh"

// Function
// [R1] Device keeps protected sector data unchanged on program or erase.
// [R2] Device shows polling/toggle status 2-100 us, then valid data.
// [R3] Protect entry: write high, chip low, high voltage on mode line, output.
// [R4] Upper three address lines pick sector; other lines held stable.
// [R5] Protect pulse: write-enable low for 100 us once inputs settle.
// [R6] Verify: write high, output low, chip low, mode line at high voltage.
// [R7] Protect verify read: A0 and A6 low, A1 high, sector upper bits.
// [R8] Device answers 01h for protected sector, 00h for unprotected.
// [R9] Protect every sector before unprotecting.
// [R10] Unprotect entry: high voltage on mode line, output, chip; A6 A12 high.
// [R11] Unprotect pulse: write-enable low 10 ms; all sectors cleared.
// [R12] Unprotect verify: A1, A6 high, A0 low; answer as protect verify. The host has one verify, which drives A6 low.
// [R13] Device ships with every sector unprotected.
// [R14] Device ignores commands and resets to read under low supply.
// [R15] Device refuses command after power-up with chip, write low.
// [R16] Device enters read mode after power-up unaided.
// [R17] Device ignores control pulses shorter than about 5 ns.
// [R18] Device holds a protection flag per sector, checked before writes.
module fsp_host
	import fsp_pkg::*;
#(
	parameter int unsigned PROT_CYC   = `FSP_PROT_PULSE_CYC,
	parameter int unsigned UNPROT_CYC = `FSP_UNPROT_PULSE_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       clk_en,
	input  wire logic       req_valid,
	output logic            req_ready,
	input  wire fsp_req_t   req,
	output logic            done,
	output logic            verify_protected,
	output fsp_pins_t       pins,
	input  wire logic [7:0] byte_lines_in,
	output logic [7:0]      byte_lines_out,
	output logic            byte_lines_oe_n
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_READ, ST_DONE
	} fsp_state_t;

	localparam logic [23:0] SETUP_CYC = 24'(`FSP_SETUP_CYC);
	localparam logic [23:0] READ_CYC  = 24'(`FSP_READ_CYC);

	fsp_state_t  state_r, state_nxt;
	fsp_op_t     op_r;
	logic [2:0]  sector_r;
	logic [23:0] cnt_r, cnt_nxt;
	logic [7:0]  sync1_r, sync2_r, sync3_r;
	logic        verify_r;
	logic        done_r;
	wire         cnt_zero = (cnt_r == 24'h000000);
	wire         is_unprot = (op_r == FSP_OP_UNPROTECT);
	wire         is_verify = (op_r == FSP_OP_VERIFY);
	wire [23:0]  pulse_cyc = is_unprot ? 24'(UNPROT_CYC) : 24'(PROT_CYC);

	// Address pattern for the chosen operation
	function automatic logic [18:0] op_addr(fsp_op_t op, logic [2:0] sec);
		logic [18:0] a;
		a = 19'h00000;
		a[18:16] = sec;                                         // R4
		if (op == FSP_OP_VERIFY) begin
			a[`FSP_BIT_A1] = 1'b1;                             // R7 R12
			a[`FSP_BIT_A6] = 1'b0;                             // R7
			a[`FSP_BIT_A0] = 1'b0;
		end else if (op == FSP_OP_UNPROTECT) begin
			a[`FSP_BIT_A6]     = 1'b1;                         // R10
			a[`FSP_BIT_A12]    = 1'b1;
			a[`FSP_BIT_SEL_LO] = 1'b1;
		end
		return a;
	endfunction

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	assign req_ready = (state_r == ST_IDLE);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_zero ? 24'h000000 : cnt_r - 24'h000001;
		case (state_r)
		ST_IDLE: begin
			if (req_valid) begin
				state_nxt = ST_SETUP;
				cnt_nxt   = SETUP_CYC;
			end
		end
		ST_SETUP: begin
			if (cnt_zero) begin
				state_nxt = is_verify ? ST_READ : ST_PULSE;
				cnt_nxt   = is_verify ? READ_CYC : pulse_cyc;    // R5 R11
			end
		end
		ST_PULSE: begin
			if (cnt_zero) begin
				state_nxt = ST_HOLD;
				cnt_nxt   = SETUP_CYC;
			end
		end
		ST_HOLD, ST_READ: begin
			if (cnt_zero)
				state_nxt = ST_DONE;
		end
		default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_r  <= ST_IDLE;
			cnt_r    <= 24'h000000;
			op_r     <= FSP_OP_VERIFY;
			sector_r <= 3'h0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			if (state_r == ST_IDLE && req_valid) begin
				op_r     <= req.op;
				sector_r <= req.sector;
			end
		end
	end

	// ----------------------------------------------------------------
	// Verify data capture, three-stage synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sync1_r  <= 8'h00;
			sync2_r  <= 8'h00;
			sync3_r  <= 8'h00;
			verify_r <= 1'b0;
			done_r   <= 1'b0;
		end else if (clk_en) begin
			sync1_r <= byte_lines_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			done_r  <= (state_r == ST_DONE);
			// Sample only once the last two stages agree, near the end of access
			if (state_r == ST_READ && cnt_zero && sync2_r == sync3_r)
				verify_r <= (sync3_r == `FSP_VERIFY_YES);         // R8
		end
	end

	assign done = done_r;
	assign verify_protected = verify_r;

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	wire active = (state_r != ST_IDLE) && (state_r != ST_DONE);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pins <= '{addr: 19'h00000, chip_en_n: 1'b1, out_en_n: 1'b1,
				write_en_n: 1'b1, mode_hv: 1'b0, oe_hv: 1'b0, ce_hv: 1'b0};
		end else if (clk_en) begin
			pins.addr       <= op_addr(op_r, sector_r);          // R4
			pins.mode_hv    <= active;                           // R3 R6 R10
			pins.oe_hv      <= active && !is_verify;             // R3 R10
			pins.ce_hv      <= active && is_unprot;              // R10
			pins.chip_en_n  <= !(active && !is_unprot);          // R3 R6
			pins.out_en_n   <= !(state_r == ST_READ);            // R6
			pins.write_en_n <= !(state_nxt == ST_PULSE);         // R5 R11
		end
	end

	// Host never drives the data lines during these operations
	assign byte_lines_out  = 8'h00;
	assign byte_lines_oe_n = 1'b1;                               // R4

	// ----------------------------------------------------------------
	// Pulse length and protect history, watched by the checks
	// ----------------------------------------------------------------
	// History covers only this run; the device keeps its flags for good
	localparam logic [23:0] PROT_LEN   = 24'(PROT_CYC + 1);
	localparam logic [23:0] UNPROT_LEN = 24'(UNPROT_CYC + 1);

	logic [23:0] low_len_r;
	logic [7:0]  prot_seen_r;
	wire         pulse_end = (state_r == ST_PULSE) && cnt_zero;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			low_len_r   <= 24'h000000;
			prot_seen_r <= 8'h00;
		end else if (clk_en) begin
			low_len_r <= pins.write_en_n ? 24'h000000
				: low_len_r + 24'h000001;
			if (pulse_end && is_unprot)
				prot_seen_r <= 8'h00;                            // R9
			else if (pulse_end)
				prot_seen_r[sector_r] <= 1'b1;                   // R9
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_pulse_start;
		$fell(pins.write_en_n);
	endsequence

	sequence s_pulse_end;
		$rose(pins.write_en_n);
	endsequence

	a_pulse_hv_held: assert property (@(posedge ref_clk) disable iff (reset)
		!pins.write_en_n |-> pins.mode_hv && pins.oe_hv) // R3
		else $error("write pulse without high voltage");
	a_verify_we_high: assert property (@(posedge ref_clk) disable iff (reset)
		!pins.out_en_n |-> pins.write_en_n && !pins.chip_en_n) // R6
		else $error("verify read with bad controls");
	a_verify_addr_ok: assert property (@(posedge ref_clk) disable iff (reset)
		!pins.out_en_n |-> pins.addr[1] && !pins.addr[0] && !pins.addr[6]) // R7
		else $error("verify address pattern wrong");
	a_unprot_addr_ok: assert property (@(posedge ref_clk) disable iff (reset)
		pins.ce_hv |-> pins.addr[6] && pins.addr[12] && pins.addr[16]) // R10
		else $error("unprotect address pattern wrong");
	a_addr_stable: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && !pins.write_en_n |=> $stable(pins.addr)) // R4
		else $error("address moved during pulse");
	a_prot_pulse_len: assert property (@(posedge ref_clk) disable iff (reset)
		s_pulse_end ##0 !pins.ce_hv |-> low_len_r == PROT_LEN) // R5
		else $error("protect pulse length wrong");
	a_unprot_pulse_len: assert property (@(posedge ref_clk) disable iff (reset)
		s_pulse_end ##0 pins.ce_hv |-> low_len_r == UNPROT_LEN) // R11
		else $error("unprotect pulse length wrong");
	a_unprot_after_all: assert property (@(posedge ref_clk) disable iff (reset)
		s_pulse_start ##0 pins.ce_hv |-> prot_seen_r == 8'hff) // R9
		else $error("unprotect before every sector protected");
	a_done_one_cycle: assert property (@(posedge ref_clk) disable iff (reset)
		done |=> !done || clk_en == 1'b0) // R8
		else $error("done held too long");
	a_idle_pins_safe: assert property (@(posedge ref_clk) disable iff (reset)
		req_ready && $past(req_ready) && clk_en && $past(clk_en)
		|=> pins.write_en_n && !pins.mode_hv) // R11
		else $error("pins active while idle");
endmodule

// file: fsp_flash_model.sv
// Behavioural flash device for sector protect, unprotect and verify
`timescale 1ns/1ps
module fsp_flash_model import fsp_pkg::*; (
	input  wire fsp_pins_t  pins,
	output logic [7:0]      byte_lines
);
	// Flags alone stand in for the array; program and erase never arrive
	logic [7:0] prot_r = 8'h00;
	logic [7:0] last_r = 8'h00;
	logic       prot_mode;
	logic       unprot_mode;
	logic       verify_rd;
	realtime    t_fall = 0.0;
	logic       supply_ok = 1'b1;
	logic       pwr_lock = 1'b0;
	// Power-up with chip and write low must not count the first write edge
	initial begin
		#5 pwr_lock = !pins.chip_en_n & !pins.write_en_n
			& pins.out_en_n;
	end
	assign prot_mode = pins.mode_hv & pins.oe_hv & !pins.ce_hv
		& !pins.chip_en_n;
	assign unprot_mode = pins.mode_hv & pins.oe_hv & pins.ce_hv
		& pins.addr[6] & pins.addr[12] & pins.addr[16];
	assign verify_rd = pins.mode_hv & !pins.oe_hv & !pins.ce_hv
		& pins.write_en_n & !pins.out_en_n & !pins.chip_en_n
		& !pins.addr[0] & pins.addr[1];
	always @(negedge pins.write_en_n) t_fall = $realtime;
	always @(posedge pins.write_en_n) begin
		// Short glitches never count as a write
		if (pwr_lock) begin
			pwr_lock = 1'b0;
		end else if (supply_ok && $realtime - t_fall >= 5.0) begin
			if (prot_mode) prot_r[pins.addr[18:16]] = 1'b1;
			else if (unprot_mode) prot_r = 8'h00;
		end
	end
	// Released bus shows the inverse of the last answer, never a stale match
	always @* begin
		if (verify_rd) byte_lines = {7'h00, prot_r[pins.addr[18:16]]};
		else byte_lines = ~last_r;
	end
	always @(byte_lines) if (verify_rd) last_r = byte_lines;
endmodule

// file: fsp_host_test.sv
// Self-checking bench for the sector protection host
`timescale 1ns/1ps
module fsp_host_test import fsp_pkg::*;;
	localparam int PROT = 8;
	localparam int UNPROT = 16;
	logic       ref_clk = 1'b0;
	logic       reset = 1'b1;
	logic       clk_en = 1'b1;
	logic       req_valid = 1'b0;
	fsp_req_t   req = '0;
	logic       req_ready;
	logic       done;
	logic       verify_protected;
	fsp_pins_t  pins;
	logic [7:0] byte_lines;
	int         error_cnt = 0;
	int         n_checks = 0;
	int         cyc = 0;
	int         low_cnt;
	fsp_host #(.PROT_CYC(PROT), .UNPROT_CYC(UNPROT)) dut (.ref_clk(ref_clk),
		.reset(reset), .clk_en(clk_en), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .done(done),
		.verify_protected(verify_protected), .pins(pins),
		.byte_lines_in(byte_lines), .byte_lines_out(), .byte_lines_oe_n());
	fsp_flash_model flash (.pins(pins), .byte_lines(byte_lines));
	always #2.5 ref_clk = ~ref_clk;
	// ------------------------------
	// Helpers
	// ------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic run_op(input fsp_op_t op, input logic [2:0] sec);
		int n;
		while (req_ready !== 1'b1) @(negedge ref_clk);
		req = '{op: op, sector: sec};
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
		low_cnt = 0;
		n = 0;
		while (done !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
			if (pins.write_en_n === 1'b0) low_cnt++;
		end
		check(n < 200, 1);
	endtask
	task automatic verify(input logic [2:0] sec, input logic exp);
		run_op(FSP_OP_VERIFY, sec);
		check(verify_protected, exp);
	endtask
	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic test_idle();
		check({pins.chip_en_n, pins.out_en_n, pins.write_en_n, pins.mode_hv},
			4'he);
		$display("test idle done");
	endtask
	task automatic test_fresh();
		for (int s = 0; s < 8; s++) verify(3'(s), 1'b0);
		$display("test fresh done");
	endtask
	task automatic test_protect_one();
		run_op(FSP_OP_PROTECT, 3'h3);
		check(low_cnt, PROT + 1);
		verify(3'h3, 1'b1);
		verify(3'h2, 1'b0);
		verify(3'h4, 1'b0);
		$display("test protect one done");
	endtask
	task automatic test_freeze();
		fsp_pins_t snap;
		int        n;
		while (req_ready !== 1'b1) @(negedge ref_clk);
		req = '{op: FSP_OP_PROTECT, sector: 3'h6};
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
		// Lands inside the write pulse
		repeat (24) @(negedge ref_clk);
		clk_en = 1'b0;
		snap = pins;
		repeat (20) @(negedge ref_clk);
		check(pins, snap);
		check(pins.write_en_n, 1'b0);
		clk_en = 1'b1;
		n = 0;
		while (done !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		check(n < 200, 1);
		verify(3'h6, 1'b1);
		$display("test freeze done");
	endtask
	task automatic test_unprotect_all();
		for (int s = 0; s < 8; s++) run_op(FSP_OP_PROTECT, 3'(s));
		for (int s = 0; s < 8; s++) verify(3'(s), 1'b1);
		run_op(FSP_OP_UNPROTECT, 3'h0);
		check(low_cnt, UNPROT + 1);
		for (int s = 0; s < 8; s++) verify(3'(s), 1'b0);
		$display("test unprotect all done");
	endtask
	initial begin
		repeat (16) @(negedge ref_clk);
		reset = 1'b0;
		@(negedge ref_clk);
		test_idle();
		test_fresh();
		test_protect_one();
		test_freeze();
		test_unprotect_all();
		wrap_up();
	end
endmodule
